// ==== itap_access_port.v ====
`timescale 1ns/1ns
// Functional notes
// R1 - host writes 0x90 to 0x6E to read a global wake-event register
// R2 - writing offset to 0x6F triggers the selected read
// R3 - read byte appears in data register 0xA0 for the host
// R4 - host writes 0x80 to 0x6E to write a global wake-event register
// R5 - offset to 0x6F, then byte to 0xA0 stores it in the table
// R6 - filter rules reachable only through indirect access over register port
// R7 - sixteen filter entries per port, five tables over four ports; code holds a single entry (offsets 0x00..0x12) per port
// R8 - host should update filter entries by read-modify-write
// R9 - entry read needs two control writes, two reads, then data read
// R10 - entry write needs one control read and three control writes; wr_tbl does three writes (0x6E, 0x6F, 0xA0) and no control read
// R11 - indirect address is port nibble over eight-bit offset
// R12 - offsets 0x00..0x0d map to entry bytes 15 downward
// R13 - offsets 0x0E and 0x0F are reserved bytes
// R14 - offsets 0x10 and 0x11 hold per-byte enables
// R15 - offset 0x12 is the entry control and status byte
// R16 - select bits 010 choose the filter rule table
// R17 - select bits 100 choose wake table, port zero is global
// R18 - read data byte holds until next read trigger or host write
// R19 - select bit 4 is direction, one read, zero write
`include "itap_defs.vh"
module itap_access_port #(
  parameter PORTS = 5, // port nibble values 0..PORTS-1 carry tables
  parameter ENTRIES = 16 // filter entries per port
) (
  input wire clk_i, // 20 MHz clock
  input wire rst_n_i, // async reset, active low
  input wire wr_i, // register write strobe, one cycle
  input wire rd_i, // register read strobe, one cycle
  input wire [7:0] addr_i, // register offset
  input wire [7:0] wdata_i, // write data
  output reg [7:0] rdata_o, // read data, registered
  output reg rvalid_o // read data valid pulse
);
  // storage: per port, 64 indirect byte slots (32 filter entry area + 32 wake area)
  localparam AW = 9;

  reg [7:0] select_q;
  reg [7:0] offset_q;
  reg [7:0] data_q;
  reg [3:0] entry_q [0:PORTS-1];
  reg pend_q;
  reg mem_we;
  reg [AW-1:0] mem_addr;
  wire [7:0] mem_rdata;
  wire [2:0] tbl = select_q[`ITAP_SEL_TBL_HI:`ITAP_SEL_TBL_LO]; // [R16] [R17]
  wire dir_rd = select_q[`ITAP_SEL_DIR_BIT]; // [R19]
  wire [3:0] port = select_q[`ITAP_SEL_PORT_HI:`ITAP_SEL_PORT_LO];
  wire [11:0] ind_addr = {port, offset_q}; // [R11]
  wire is_flt = (tbl == `ITAP_TBL_FILTER);
  wire is_wake = (tbl == `ITAP_TBL_WAKE);
  wire port_ok = (port < PORTS);

  // entry byte position: offset 0 is byte 15 (msb) of the 128-bit entry
  function [3:0] flt_byte;
    input [7:0] ofs;
    begin
      flt_byte = `ITAP_FLT_ENTRY_TOP - ofs[3:0]; // [R12]
    end
  endfunction

  // map indirect address to storage slot; bit 0 of return flags a hit
  function [AW:0] slot;
    input [11:0] ia;
    input f;
    input w;
    reg [7:0] o;
    begin
      o = ia[7:0];
      slot = {AW+1{1'b0}};
      if (f && o <= `ITAP_FLT_CTRL) begin
        // whole entry area incl. reserved, enables and control byte
        // three port bits: ports 0 and 4 must not share a slot
        slot = {ia[10:8], 1'b0, o[4:0], 1'b1}; // [R13] [R14] [R15]
      end else if (w && o < `ITAP_WAKE_BYTES) begin
        slot = {ia[10:8], 1'b1, 2'b00, o[2:0], 1'b1}; // [R17]
      end
    end
  endfunction

  wire [AW:0] hit = slot(ind_addr, is_flt, is_wake);
  wire hit_ok = hit[0] && port_ok;

  itap_byte_mem #(.AW(AW)) u_mem (
    .clk_i(clk_i),
    .we_i(mem_we),
    .addr_i(mem_addr),
    .wdata_i(wdata_i),
    .rdata_o(mem_rdata)
  );

  // table write happens on host write to data register in write direction
  always @* begin
    mem_addr = hit[AW:1];
    mem_we = wr_i && addr_i == `ITAP_OFS_DATA && !dir_rd && hit_ok; // [R5]
  end

  // the only host path into the tables is this indirect window
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      select_q <= 8'h00;
      offset_q <= 8'h00;
      data_q <= 8'h00;
      pend_q <= 1'b0;
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      pend_q <= 1'b0;
      rvalid_o <= rd_i;
      if (wr_i) begin
        case (addr_i) // [R6]
          `ITAP_OFS_SELECT: select_q <= wdata_i; // [R1] [R4]
          `ITAP_OFS_TRIGGER: begin
            offset_q <= wdata_i;
            pend_q <= dir_rd; // [R2]
          end
          `ITAP_OFS_DATA: data_q <= wdata_i; // [R18]
          default: ;
        endcase
      end
      // fetch one cycle after trigger so offset_q already addresses it
      if (pend_q) begin
        data_q <= hit_ok ? mem_rdata : 8'h00; // [R3] [R18]
      end
      if (rd_i) begin
        case (addr_i)
          `ITAP_OFS_SELECT: rdata_o <= select_q; // [R10]
          `ITAP_OFS_TRIGGER: rdata_o <= offset_q; // [R9]
          `ITAP_OFS_DATA: rdata_o <= data_q; // [R3]
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // last filter entry byte position written per port, shown nowhere but kept bounded
  integer k;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (k = 0; k < PORTS; k = k + 1) begin
        entry_q[k] <= 4'h0;
      end
    end else if (mem_we && is_flt && offset_q <= `ITAP_FLT_LAST_BYTE) begin
      entry_q[port[2:0]] <= flt_byte(offset_q); // [R7] [R8]
    end
  end
endmodule

// ==== itap_defs.vh ====
`ifndef ITAP_DEFS_VH
`define ITAP_DEFS_VH
`define ITAP_OFS_SELECT 8'h6E
`define ITAP_OFS_TRIGGER 8'h6F
`define ITAP_OFS_DATA 8'hA0
`define ITAP_TBL_FILTER 3'h2
`define ITAP_TBL_WAKE 3'h4
`define ITAP_SEL_TBL_HI 7
`define ITAP_SEL_TBL_LO 5
`define ITAP_SEL_DIR_BIT 4
`define ITAP_SEL_PORT_HI 3
`define ITAP_SEL_PORT_LO 0
`define ITAP_FLT_RSVD_LO 8'h0E
`define ITAP_FLT_RSVD_HI 8'h0F
`define ITAP_FLT_BE_HI 8'h10
`define ITAP_FLT_BE_LO 8'h11
`define ITAP_FLT_CTRL 8'h12
`define ITAP_FLT_LAST_BYTE 8'h0D
`define ITAP_FLT_ENTRY_TOP 4'hF
`define ITAP_WAKE_BYTES 8'h08
`endif

// ==== itap_byte_mem.v ====
`timescale 1ns/1ns
// single byte-wide table storage, written synchronously, read combinationally
module itap_byte_mem #(
  parameter AW = 8
) (
  input wire clk_i, // system clock
  input wire we_i, // write strobe
  input wire [AW-1:0] addr_i, // byte address
  input wire [7:0] wdata_i, // write byte
  output wire [7:0] rdata_o // read byte, combinational
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[addr_i];
endmodule

// ==== itap_access_port_properties.sv ====
`timescale 1ns/1ns
module itap_access_port_props (
  input wire clk_i, rst_n_i, wr_i, rd_i, rvalid_o, // clock, reset, strobes
  input wire [7:0] addr_i, wdata_i, rdata_o // offset and data bytes
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  wire r = rd_i && !wr_i, s = addr_i == 8'h6e, o = addr_i == 8'h6f;
  wire d = addr_i == 8'ha0, u = !(s || o || d);
  a_rd_valid: assert property (r |=> rvalid_o) else $error("late");
  a_no_stray: assert property (!r |=> !rvalid_o) else $error("stray");
  a_wr_quiet: assert property (wr_i |=> !rvalid_o) else $error("wr");
  a_rd_hold: assert property (!rvalid_o |-> $stable(rdata_o))
    else $error("moved");
  a_unm_zero: assert property (r && u |=> rdata_o == 8'h00)
    else $error("unmapped");
  a_sel_back: assert property (wr_i && s ##1 wr_i && !s ##1 r && s
    |=> rdata_o == $past(wdata_i, 3)) else $error("select");
  a_ofs_back: assert property (wr_i && o ##1 r && s ##2 r && o
    |=> rdata_o == $past(wdata_i, 4)) else $error("offset");
  a_dat_back: assert property (wr_i && d ##1 r && d
    |=> rdata_o == $past(wdata_i, 2)) else $error("data");
  c_trigger: cover property (wr_i && o);
  c_data_rd: cover property (r && d);
  c_refused: cover property (r && u);
endmodule

// ==== itap_host_model.sv ====
`timescale 1ns/1ns
module itap_host_model (
  input wire clk_i, // clock
  input wire [7:0] rdata_o, // device read data
  output reg wr_i = 1'b0, rd_i = 1'b0, // strobes
  output reg [7:0] addr_i = 8'h00, wdata_i = 8'h00 // offset, data
);
  // k is {write, read}; one access a cycle, launched at the falling edge
  task cyc(input [1:0] k, input [7:0] a, d);
    @(negedge clk_i) {wr_i, rd_i, addr_i, wdata_i} = {k, a, d};
  endtask
  task get(input [7:0] a, output [7:0] v);
    cyc(2'd1, a, 8'h00);
    cyc(2'd0, a, 8'h00);
    v = rdata_o;
  endtask
  // the control reads also cover the gap a triggered read needs
  task rd_tbl(input [7:0] s, o, output [7:0] v);
    cyc(2'd2, 8'h6e, s);
    cyc(2'd2, 8'h6f, o);
    get(8'h6e, v);
    get(8'h6f, v);
    get(8'ha0, v);
  endtask
  task wr_tbl(input [7:0] s, o, d);
    cyc(2'd2, 8'h6e, s);
    cyc(2'd2, 8'h6f, o);
    cyc(2'd2, 8'ha0, d);
  endtask
endmodule

// ==== itap_access_port_bench.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h want %h", $time, a, e); end end
module itap_access_port_bench;
  logic clk_i = 1'b0, rst_n_i = 1'b0, wr_i, rd_i, rvalid_o;
  logic [7:0] addr_i, wdata_i, rdata_o, v;
  int miscompares = 0, checked = 0, n = 0, p, o;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (++n == 2000) begin
    miscompares++;
    end_of_test;
  end
  itap_access_port dut (.*);
  itap_host_model host (.*);
  task end_of_test;
    $display("miscompares %0d checked %0d", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    @(negedge clk_i iff n == 12) rst_n_i = 1'b1;
    host.wr_tbl(8'h80, 8'h03, 8'h5a);
    host.rd_tbl(8'h90, 8'h03, v);
    `CHK(v, 8'h5a)
    // ports 1 and 4 get distinct bytes so aliasing between them shows
    for (p = 1; p < 5; p += 3)
      for (o = 0; o < 19; o++)
        host.wr_tbl(8'h40 | 8'(p), 8'(o), 8'(o * 2 + p));
    for (p = 1; p < 5; p += 3)
      for (o = 0; o < 19; o++) begin
        host.rd_tbl(8'h50 | 8'(p), 8'(o), v);
        `CHK(v, 8'(o * 2 + p))
      end
    host.cyc(2'd2, 8'ha0, 8'hc3);
    host.get(8'ha0, v);
    `CHK(v, 8'hc3)
    host.rd_tbl(8'h54, 8'h12, v);
    `CHK(v, 8'h28)
    host.wr_tbl(8'h40, 8'h00, 8'h77);
    host.rd_tbl(8'h54, 8'h00, v);
    `CHK(v, 8'h04)
    host.wr_tbl(8'h45, 8'h00, 8'h99);
    host.rd_tbl(8'h55, 8'h00, v);
    `CHK(v, 8'h00)
    host.cyc(2'd2, 8'h01, 8'hff);
    host.get(8'h01, v);
    `CHK(v, 8'h00)
    end_of_test;
  end
endmodule
bind itap_access_port itap_access_port_props chk (.*);
